// ### core/fspc_pkg.sv
package fspc_pkg;

  // ==========================================================
  // register map (word index, byte address is four times it)
  // ==========================================================
  localparam logic [5:0]  CTRL_INDEX   = 6'h37;
  localparam logic [5:0]  EXT_INDEX    = 6'h38;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [1:0]  EXT_RESET    = 2'h0;

  // ==========================================================
  // command patterns in the lower five control bits
  // ==========================================================
  localparam logic [4:0]  CMD_FILL     = 5'h01;
  localparam logic [4:0]  CMD_ERASE    = 5'h03;
  localparam logic [4:0]  CMD_WRITE    = 5'h05;
  localparam logic [4:0]  CMD_LOCK     = 5'h09;
  localparam logic [4:0]  CMD_RWW      = 5'h11;

  // ==========================================================
  // arming windows in clock cycles
  // ==========================================================
  localparam logic [2:0]  STORE_WIN    = 3'h4;
  localparam logic [2:0]  LOAD_WIN     = 3'h3;
  localparam logic [2:0]  ARM_LAST     = STORE_WIN - 3'h1;

  // ==========================================================
  // flash geometry
  // ==========================================================
  localparam int          PC_WIDTH     = 17;
  localparam int          PAGE_WIDTH   = 10;
  localparam int          WORD_WIDTH   = 7;
  localparam logic [16:0] BOOT_START_3 = 17'h1_FE00;
  localparam logic [16:0] BOOT_START_2 = 17'h1_FC00;
  localparam logic [16:0] BOOT_START_1 = 17'h1_F800;
  localparam logic [16:0] BOOT_START_0 = 17'h1_F000;
  localparam logic [5:0]  BOOT_PAGES_3 = 6'h04;
  localparam logic [5:0]  BOOT_PAGES_2 = 6'h08;
  localparam logic [5:0]  BOOT_PAGES_1 = 6'h10;
  localparam logic [5:0]  BOOT_PAGES_0 = 6'h20;
  localparam logic [16:0] BLOCKING_REGION_START   = 17'h1_F000;
  localparam logic [9:0]  BLOCKING_REGION_PAGE    = BLOCKING_REGION_START[16:7];

  // ==========================================================
  // types
  // ==========================================================
  typedef struct packed {
    logic irq_en;
    logic busy;
    logic sig_read;
    logic rww_en;
    logic lock_set;
    logic pg_write;
    logic pg_erase;
    logic store_en;
  } fspc_ctrl_type;

  typedef struct packed {
    logic [16:0] start;
    logic [5:0]  pages;
  } fspc_boot_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_BUSY  = 2'b11
  } fspc_state_type;

  typedef enum logic [1:0] {
    LD_FLASH = 2'b00,
    LD_SIG   = 2'b01,
    LD_LOCK  = 2'b10,
    LD_FUSE  = 2'b11
  } fspc_load_type;

endpackage

// ### core/fspc_top.sv
// The implementer's own choice: the Avalon-MM slave port.
module fspc_top
  import fspc_pkg::*;
#(
  parameter logic [15:0] PROG_CYCLES = 16'h0100
) (
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [1:0]  BOOT_SIZE,
  input  wire logic        CORE_STORE,
  input  wire logic        CORE_LOAD,
  input  wire logic [15:0] CORE_POINTER,
  input  wire logic [7:0]  CORE_SRC_LOW,
  input  wire logic [7:0]  CORE_SRC_HIGH,
  input  wire logic        CORE_GLOBAL_IRQ,
  output logic             IRQ_REQ,
  output logic             CORE_HALT,
  output logic             SECTION_BUSY,
  output logic             BUF_WE,
  output logic      [6:0]  BUF_WORD,
  output logic      [15:0] BUF_DATA,
  output logic             BUF_DISCARD,
  output logic             FLASH_ERASE,
  output logic             FLASH_WRITE,
  output logic      [9:0]  FLASH_PAGE,
  output logic             LOCK_WE,
  output logic      [7:0]  LOCK_DATA,
  output logic      [1:0]  LOAD_SEL,
  output logic      [17:0] LOAD_ADDR,
  output logic      [16:0] BOOT_START,
  output logic      [5:0]  BOOT_PAGES
);

  // ==========================================================
  // functions
  // ==========================================================
  function automatic logic cmd_legal(input logic [4:0] c);
    cmd_legal = (c == CMD_FILL) || (c == CMD_ERASE) ||
                (c == CMD_WRITE) || (c == CMD_LOCK) ||
                (c == CMD_RWW);
  endfunction

  function automatic fspc_boot_type boot_decode(input logic [1:0] sz);
    fspc_boot_type b;
    case (sz)
      2'b11: begin
        b = '{start: BOOT_START_3, pages: BOOT_PAGES_3};
      end
      2'b10: begin
        b = '{start: BOOT_START_2, pages: BOOT_PAGES_2};
      end
      2'b01: begin
        b = '{start: BOOT_START_1, pages: BOOT_PAGES_1};
      end
      default: begin
        b = '{start: BOOT_START_0, pages: BOOT_PAGES_0};
      end
    endcase
    boot_decode = b;
  endfunction

  function automatic logic page_blocking(input logic [9:0] p);
    page_blocking = (p >= BLOCKING_REGION_PAGE);
  endfunction

  // ==========================================================
  // state
  // ==========================================================
  logic [1:0]     boot_sync1_q;
  logic [1:0]     boot_sync2_q;
  logic           wait_q;
  logic [31:0]    rdata_q;
  fspc_ctrl_type  ctrl_q;
  fspc_state_type state_q;
  logic [2:0]     elapsed_q;
  logic [15:0]    op_cnt_q;
  logic [1:0]     ext_q;
  logic           loaded_q;
  logic           halt_q;
  logic           irq_q;
  fspc_boot_type  boot_q;
  logic           buf_we_q;
  logic [6:0]     buf_word_q;
  logic [15:0]    buf_data_q;
  logic           discard_q;
  logic           erase_q;
  logic           write_q;
  logic [9:0]     page_q;
  logic           lock_we_q;
  logic [7:0]     lock_data_q;
  fspc_load_type  load_sel_q;
  logic [17:0]    load_addr_q;

  // ==========================================================
  // decode
  // ==========================================================
  fspc_ctrl_type  wdata;
  logic [4:0]     cmd;
  logic           wr_ctrl;
  logic           wr_ext;
  logic           armed;
  logic           store_hit;
  logic           load_hit;
  logic           fill;
  logic           lock;
  logic           reenable;
  logic           start_op;
  logic           op_done;
  logic [9:0]     page;
  logic           discard;

  always_comb begin
    wdata     = fspc_ctrl_type'(AVS_WRITEDATA[7:0]);
    cmd       = {ctrl_q.rww_en, ctrl_q.lock_set, ctrl_q.pg_write,
                 ctrl_q.pg_erase, ctrl_q.store_en};
    wr_ctrl   = AVS_WRITE && !wait_q && AVS_BYTEENABLE[0] &&
                (AVS_ADDRESS[7:2] == CTRL_INDEX);
    wr_ext    = AVS_WRITE && !wait_q && AVS_BYTEENABLE[0] &&
                (AVS_ADDRESS[7:2] == EXT_INDEX);
    armed     = (state_q == ST_ARMED);
    store_hit = armed && CORE_STORE;
    load_hit  = armed && CORE_LOAD && (elapsed_q < LOAD_WIN);
    page      = {ext_q, CORE_POINTER[15:8]};
    fill      = store_hit && (cmd == CMD_FILL) && !ctrl_q.sig_read;
    lock      = store_hit && (cmd == CMD_LOCK);
    reenable  = store_hit && (cmd == CMD_RWW);
    start_op  = store_hit && ((cmd == CMD_WRITE) || (cmd == CMD_ERASE));
    op_done   = (state_q == ST_BUSY) && (op_cnt_q == 16'h0001);
    discard   = wr_ctrl && wdata.rww_en && loaded_q;
  end

  // ==========================================================
  // strap synchroniser and boot split
  // ==========================================================
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      boot_sync1_q <= 2'h0;
      boot_sync2_q <= 2'h0;
      boot_q       <= '0;
    end else begin
      boot_sync1_q <= BOOT_SIZE;
      boot_sync2_q <= boot_sync1_q;
      boot_q       <= boot_decode(boot_sync2_q);
    end
  end

  // ==========================================================
  // avalon slave: one wait cycle per access
  // ==========================================================
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      wait_q <= 1'b1;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (AVS_READ || AVS_WRITE) begin
      wait_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (wait_q && AVS_READ) begin
      if (AVS_ADDRESS[7:2] == CTRL_INDEX) begin
        rdata_q <= {24'h00_0000, ctrl_q};
      end else if (AVS_ADDRESS[7:2] == EXT_INDEX) begin
        rdata_q <= {30'h0000_0000, ext_q};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ext_q <= EXT_RESET;
    end else if (wr_ext) begin
      ext_q <= AVS_WRITEDATA[1:0];
    end
  end

  // ==========================================================
  // command sequencer
  // ==========================================================
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ctrl_q    <= fspc_ctrl_type'(CTRL_RESET);
      state_q   <= ST_IDLE;
      elapsed_q <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.irq_en <= wdata.irq_en;
      end
      case (state_q)
        ST_IDLE, ST_ARMED: begin
          if (wr_ctrl && cmd_legal(wdata[4:0])) begin
            ctrl_q.rww_en   <= wdata.rww_en;
            ctrl_q.lock_set <= wdata.lock_set;
            ctrl_q.pg_write <= wdata.pg_write;
            ctrl_q.pg_erase <= wdata.pg_erase;
            ctrl_q.store_en <= wdata.store_en;
            ctrl_q.sig_read <= wdata.sig_read && (wdata[4:0] == CMD_FILL);
            state_q         <= ST_ARMED;
            elapsed_q       <= 3'h0;
          end else if (start_op) begin
            state_q <= ST_BUSY;
          end else if (store_hit || (armed && elapsed_q == ARM_LAST)) begin
            ctrl_q.rww_en   <= 1'b0;
            ctrl_q.lock_set <= 1'b0;
            ctrl_q.pg_write <= 1'b0;
            ctrl_q.pg_erase <= 1'b0;
            ctrl_q.store_en <= 1'b0;
            ctrl_q.sig_read <= 1'b0;
            state_q         <= ST_IDLE;
          end else if (armed) begin
            elapsed_q <= elapsed_q + 3'h1;
          end
        end
        ST_BUSY: begin
          if (op_done) begin
            ctrl_q.pg_write <= 1'b0;
            ctrl_q.pg_erase <= 1'b0;
            ctrl_q.store_en <= 1'b0;
            state_q         <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      if (reenable || fill) begin
        ctrl_q.busy <= 1'b0;
      end
      if (start_op && !page_blocking(page)) begin
        ctrl_q.busy <= 1'b1;
      end
    end
  end

  // ==========================================================
  // programming timer and core halt
  // ==========================================================
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      op_cnt_q <= 16'h0000;
      halt_q   <= 1'b0;
    end else if (start_op) begin
      op_cnt_q <= PROG_CYCLES;
      halt_q   <= page_blocking(page);
    end else if (state_q == ST_BUSY) begin
      op_cnt_q <= op_cnt_q - 16'h0001;
      if (op_done) begin
        halt_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // temporary buffer fill and discard
  // ==========================================================
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      loaded_q   <= 1'b0;
      buf_we_q   <= 1'b0;
      buf_word_q <= 7'h00;
      buf_data_q <= 16'h0000;
      discard_q  <= 1'b0;
    end else begin
      buf_we_q  <= fill;
      discard_q <= discard;
      if (fill) begin
        buf_word_q <= CORE_POINTER[7:1];
        buf_data_q <= {CORE_SRC_HIGH, CORE_SRC_LOW};
        loaded_q   <= 1'b1;
      end else if (discard || (start_op && cmd == CMD_WRITE)) begin
        loaded_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // flash erase/write and lock bit requests
  // ==========================================================
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      erase_q     <= 1'b0;
      write_q     <= 1'b0;
      page_q      <= 10'h000;
      lock_we_q   <= 1'b0;
      lock_data_q <= 8'h00;
    end else begin
      erase_q   <= start_op && (cmd == CMD_ERASE);
      write_q   <= start_op && (cmd == CMD_WRITE);
      lock_we_q <= lock;
      if (start_op) begin
        page_q <= page;
      end
      if (lock) begin
        lock_data_q <= CORE_SRC_LOW;
      end
    end
  end

  // ==========================================================
  // load source select and interrupt request
  // ==========================================================
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      load_sel_q  <= LD_FLASH;
      load_addr_q <= 18'h0_0000;
    end else if (CORE_LOAD) begin
      load_addr_q <= {ext_q, CORE_POINTER};
      if (load_hit && ctrl_q.sig_read) begin
        load_sel_q <= LD_SIG;
      end else if (load_hit && cmd == CMD_LOCK) begin
        load_sel_q <= CORE_POINTER[0] ? LD_LOCK : LD_FUSE;
      end else begin
        load_sel_q <= LD_FLASH;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ctrl_q.irq_en && CORE_GLOBAL_IRQ && !ctrl_q.store_en;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign IRQ_REQ         = irq_q;
  assign CORE_HALT       = halt_q;
  assign SECTION_BUSY    = ctrl_q.busy;
  assign BUF_WE          = buf_we_q;
  assign BUF_WORD        = buf_word_q;
  assign BUF_DATA        = buf_data_q;
  assign BUF_DISCARD     = discard_q;
  assign FLASH_ERASE     = erase_q;
  assign FLASH_WRITE     = write_q;
  assign FLASH_PAGE      = page_q;
  assign LOCK_WE         = lock_we_q;
  assign LOCK_DATA       = lock_data_q;
  assign LOAD_SEL        = load_sel_q;
  assign LOAD_ADDR       = load_addr_q;
  assign BOOT_START      = boot_q.start;
  assign BOOT_PAGES      = boot_q.pages;

endmodule // fspc_top

// ### testbench/fspc_core_model.sv
// ====================================
// core issuing store and load instructions
// ====================================
module fspc_core_model (
  input wire logic        clk_sys,
  output logic            core_store,
  output logic            core_load,
  output logic     [15:0] core_pointer,
  output logic     [7:0]  core_src_low,
  output logic     [7:0]  core_src_high
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    core_store    = 1'b0;
    core_load     = 1'b0;
    core_pointer  = 16'h0000;
    core_src_low  = 8'h00;
    core_src_high = 8'h00;
  end

  // one instruction at a time; operands turn over once it is taken
  task automatic issue(input logic ld, input logic [15:0] ptr, input logic [15:0] src,
                       input int dly);
    repeat (dly) @(posedge clk_sys);
    core_pointer                  <= ptr;
    {core_src_high, core_src_low} <= src;
    core_load                     <= ld;
    core_store                    <= !ld;
    @(posedge clk_sys);
    core_store                    <= 1'b0;
    core_load                     <= 1'b0;
    core_pointer                  <= ~ptr;
    {core_src_high, core_src_low} <= ~src;
  endtask
endmodule // fspc_core_model

// ### testbench/fspc_top_props.sv
// ====================================
// port checks of the self-program block
// ====================================
module fspc_props
  import fspc_pkg::*;
#(
  parameter logic [15:0] PROG_CYCLES = 16'h0100
) (
  input wire logic        CLK_SYS,
  input wire logic        NRST,
  input wire logic        CORE_STORE,
  input wire logic        CORE_LOAD,
  input wire logic [15:0] CORE_POINTER,
  input wire logic [7:0]  CORE_SRC_LOW,
  input wire logic [7:0]  CORE_SRC_HIGH,
  input wire logic        CORE_GLOBAL_IRQ,
  input wire logic        IRQ_REQ,
  input wire logic        CORE_HALT,
  input wire logic        SECTION_BUSY,
  input wire logic        BUF_WE,
  input wire logic [6:0]  BUF_WORD,
  input wire logic [15:0] BUF_DATA,
  input wire logic        FLASH_ERASE,
  input wire logic        FLASH_WRITE,
  input wire logic [9:0]  FLASH_PAGE,
  input wire logic        LOCK_WE,
  input wire logic [7:0]  LOCK_DATA,
  input wire logic [17:0] LOAD_ADDR
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] ptr_q;
  logic [15:0] src_q;
  logic        store_q;

  // core request seen at the previous edge
  always_ff @(posedge CLK_SYS) begin
    ptr_q   <= CORE_POINTER;
    src_q   <= {CORE_SRC_HIGH, CORE_SRC_LOW};
    store_q <= CORE_STORE;
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  a_fill_cause:
  assert property (BUF_WE |-> store_q && BUF_WORD == ptr_q[7:1] && BUF_DATA == src_q)
    else $error("buffer word not from store");
  a_lock_cause:
  assert property (LOCK_WE |-> store_q && LOCK_DATA == src_q[7:0])
    else $error("lock data not from low source");
  a_prog_cause:
  assert property ((FLASH_ERASE || FLASH_WRITE) |-> store_q && FLASH_PAGE[7:0] == ptr_q[15:8])
    else $error("program pulse without store or wrong page");
  a_one_prog_pulse:
  assert property (FLASH_ERASE |-> !FLASH_WRITE ##1 !FLASH_ERASE)
    else $error("erase pulse malformed");
  a_load_addr:
  assert property (CORE_LOAD |=> LOAD_ADDR[15:0] == ptr_q)
    else $error("load address not from pointer");
  a_halt_page:
  assert property ($rose(CORE_HALT) |-> (FLASH_ERASE || FLASH_WRITE) && FLASH_PAGE >= 10'h3E0)
    else $error("halt without blocking page program");
  a_busy_rww:
  assert property ((FLASH_ERASE || FLASH_WRITE) && FLASH_PAGE < 10'h3E0 |-> SECTION_BUSY)
    else $error("busy flag not set");
  a_halt_hold:
  assert property ($rose(CORE_HALT) |-> CORE_HALT[*3] ##[1:600] !CORE_HALT)
    else $error("halt too short or never ends");
  a_irq_gate:
  assert property (!CORE_GLOBAL_IRQ |=> !IRQ_REQ)
    else $error("interrupt without global enable");

  c_fill: cover property (BUF_WE);
  c_halt: cover property ($rose(CORE_HALT));
  c_lock: cover property (LOCK_WE);
endmodule // fspc_props

bind fspc_top fspc_props #(.PROG_CYCLES(PROG_CYCLES)) u_fspc_props (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .CORE_STORE(CORE_STORE), .CORE_LOAD(CORE_LOAD),
  .CORE_POINTER(CORE_POINTER), .CORE_SRC_LOW(CORE_SRC_LOW), .CORE_SRC_HIGH(CORE_SRC_HIGH),
  .CORE_GLOBAL_IRQ(CORE_GLOBAL_IRQ), .IRQ_REQ(IRQ_REQ), .CORE_HALT(CORE_HALT),
  .SECTION_BUSY(SECTION_BUSY), .BUF_WE(BUF_WE), .BUF_WORD(BUF_WORD), .BUF_DATA(BUF_DATA),
  .FLASH_ERASE(FLASH_ERASE), .FLASH_WRITE(FLASH_WRITE), .FLASH_PAGE(FLASH_PAGE),
  .LOCK_WE(LOCK_WE), .LOCK_DATA(LOCK_DATA), .LOAD_ADDR(LOAD_ADDR)
);

// ### testbench/testbench.sv
module testbench
  import fspc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] PROG = 16'h0008;
  localparam logic [22:0] BOOT_TAB [4] = '{{17'h1_F000, 6'h20}, {17'h1_F800, 6'h10},
                                           {17'h1_FC00, 6'h08}, {17'h1_FE00, 6'h04}};
  localparam logic [4:0]  BAD [5] = '{5'h07, 5'h13, 5'h0B, 5'h1F, 5'h10};

  logic        clk_sys = 1'b0;
  logic        nrst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  boot_size;
  logic        core_store, core_load, core_global_irq, irq_req, core_halt, section_busy;
  logic [15:0] core_pointer, buf_data;
  logic [7:0]  core_src_low, core_src_high, lock_data;
  logic        buf_we, buf_discard, flash_erase, flash_write, lock_we;
  logic [6:0]  buf_word;
  logic [9:0]  flash_page;
  logic [1:0]  load_sel;
  logic [17:0] load_addr;
  logic [16:0] boot_start;
  logic [5:0]  boot_pages;
  logic [27:0] exp_q [$];
  logic [31:0] seed = 32'h0000_0020;
  logic [31:0] r;
  logic [15:0] ptr;
  int          err_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #5 clk_sys = ~clk_sys;

  fspc_top #(.PROG_CYCLES(PROG)) u_fspc_top (
    .CLK_SYS(clk_sys), .NRST(nrst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .BOOT_SIZE(boot_size),
    .CORE_STORE(core_store), .CORE_LOAD(core_load), .CORE_POINTER(core_pointer),
    .CORE_SRC_LOW(core_src_low), .CORE_SRC_HIGH(core_src_high),
    .CORE_GLOBAL_IRQ(core_global_irq), .IRQ_REQ(irq_req), .CORE_HALT(core_halt),
    .SECTION_BUSY(section_busy), .BUF_WE(buf_we), .BUF_WORD(buf_word), .BUF_DATA(buf_data),
    .BUF_DISCARD(buf_discard), .FLASH_ERASE(flash_erase), .FLASH_WRITE(flash_write),
    .FLASH_PAGE(flash_page), .LOCK_WE(lock_we), .LOCK_DATA(lock_data), .LOAD_SEL(load_sel),
    .LOAD_ADDR(load_addr), .BOOT_START(boot_start), .BOOT_PAGES(boot_pages)
  );

  fspc_core_model u_core (
    .clk_sys(clk_sys), .core_store(core_store), .core_load(core_load),
    .core_pointer(core_pointer), .core_src_low(core_src_low), .core_src_high(core_src_high)
  );

  // ====================================
  // helpers
  // ====================================
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic test_done();
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] adr, input logic [7:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    avs_address   <= adr;
    avs_writedata <= {24'h00_0000, wd};
    avs_write     <= wr;
    avs_read      <= !wr;
    // request held until the edge that samples waitrequest low
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    logic [31:0] rd;
    bus(1'b1, adr, wd, rd);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, adr, 8'h00, rd);
    check(rd, exp);
  endtask

  task automatic wait_done();
    logic [31:0] rd;
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'hDC, 8'h00, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 30);
    check({31'h0000_0000, rd[0]}, 32'h0000_0000);
  endtask

  task automatic load_chk(input logic [15:0] p, input int dly, input logic [1:0] sel);
    u_core.issue(1'b1, p, 16'h0000, dly);
    @(negedge clk_sys);
    check({12'h000, load_sel, load_addr}, {12'h000, sel, 2'b11, p});
    @(posedge clk_sys);
  endtask

  // ====================================
  // result watcher
  // ====================================
  always @(negedge clk_sys) begin
    logic [27:0] seen;
    logic [27:0] exp_t;
    seen = 28'h000_0000;
    if (buf_we === 1'b1) seen = {4'h1, 1'b0, buf_word, buf_data};
    if (flash_erase === 1'b1) seen = {4'h2, 14'h0000, flash_page};
    if (flash_write === 1'b1) seen = {4'h3, 14'h0000, flash_page};
    if (lock_we === 1'b1) seen = {4'h4, 16'h0000, lock_data};
    if (buf_discard === 1'b1) seen = {4'h5, 24'h00_0000};
    if (seen[27:24] != 4'h0) begin
      exp_t = (exp_q.size() > 0) ? exp_q.pop_front() : 28'h000_0000;
      check({4'h0, seen}, {4'h0, exp_t});
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end

  // ====================================
  // main sequence
  // ====================================
  initial begin
    nrst            = 1'b0;
    avs_address     = 8'h00;
    avs_read        = 1'b0;
    avs_write       = 1'b0;
    avs_writedata   = 32'h0000_0000;
    boot_size       = 2'b00;
    core_global_irq = 1'b0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    rdc(8'hDC, 32'h0000_0000);
    rdc(8'hE0, 32'h0000_0000);
    wr(8'h40, 8'hFF);
    rdc(8'h40, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      boot_size <= 2'(i);
      repeat (4) @(negedge clk_sys);
      check({9'h000, boot_start, boot_pages}, {9'h000, BOOT_TAB[i]});
    end
    for (int i = 0; i < 4; i++) begin
      r   = rnd();
      ptr = {r[15:1], 1'b0};
      wr(8'hDC, 8'h01);
      exp_q.push_back({4'h1, 1'b0, ptr[7:1], r[31:16]});
      u_core.issue(1'b0, ptr, r[31:16], i);
    end
    rdc(8'hDC, 32'h0000_0000);
    wr(8'hDC, 8'h05);
    u_core.issue(1'b0, 16'h1200, 16'h0000, 4);
    rdc(8'hDC, 32'h0000_0000);
    wr(8'hDC, 8'h05);
    exp_q.push_back({4'h3, 14'h0000, 10'h012});
    u_core.issue(1'b0, 16'h1200, 16'h0000, 3);
    rdc(8'hDC, 32'h0000_0045);
    wait_done();
    rdc(8'hDC, 32'h0000_0040);
    core_global_irq <= 1'b1;
    foreach (BAD[i]) begin
      wr(8'hDC, {3'b100, BAD[i]});
      u_core.issue(1'b0, 16'h0000, 16'h0000, 0);
      rdc(8'hDC, 32'h0000_00C0);
    end
    @(negedge clk_sys);
    check({31'h0000_0000, irq_req}, 32'h0000_0001);
    wr(8'hDC, 8'h81);
    repeat (2) @(negedge clk_sys);
    check({31'h0000_0000, irq_req}, 32'h0000_0000);
    wr(8'hDC, 8'h01);
    exp_q.push_back({4'h1, 1'b0, 7'h05, 16'hA55A});
    u_core.issue(1'b0, 16'h000A, 16'hA55A, 0);
    rdc(8'hDC, 32'h0000_0000);
    wr(8'hDC, 8'h03);
    exp_q.push_back({4'h2, 14'h0000, 10'h034});
    u_core.issue(1'b0, 16'h3400, 16'h0000, 2);
    wait_done();
    rdc(8'hDC, 32'h0000_0040);
    exp_q.push_back({4'h5, 24'h00_0000});
    wr(8'hDC, 8'h11);
    u_core.issue(1'b0, 16'h0000, 16'h0000, 0);
    rdc(8'hDC, 32'h0000_0000);
    wr(8'hE0, 8'h03);
    wr(8'hDC, 8'h03);
    exp_q.push_back({4'h2, 14'h0000, 10'h3F0});
    u_core.issue(1'b0, 16'hF000, 16'h0000, 0);
    @(negedge clk_sys);
    check({30'h0000_0000, core_halt, section_busy}, 32'h0000_0002);
    wait_done();
    check({31'h0000_0000, core_halt}, 32'h0000_0000);
    r = rnd();
    wr(8'hDC, 8'h09);
    exp_q.push_back({4'h4, 16'h0000, r[7:0]});
    u_core.issue(1'b0, 16'hFFFE, r[15:0], 1);
    rdc(8'hDC, 32'h0000_0000);
    wr(8'hDC, 8'h09);
    load_chk(16'h0001, 0, 2'b10);
    wr(8'hDC, 8'h09);
    load_chk(16'h0000, 2, 2'b11);
    wr(8'hDC, 8'h21);
    load_chk(16'h0100, 1, 2'b01);
    wr(8'hDC, 8'h21);
    u_core.issue(1'b0, 16'h0000, 16'h0000, 0);
    rdc(8'hDC, 32'h0000_0000);
    load_chk(16'h1235, 0, 2'b00);
    repeat (4) @(posedge clk_sys);
    check(32'(exp_q.size()), 32'h0000_0000);
    test_done();
  end
endmodule // testbench
